/* sdma_pkg.sv */
// Notes on behaviour
// RQ1: Source code 0000 off, 1 uart0, 2 uart1, 5 twi, 7 spi, 9 adc, f expanded_ram.
// RQ2: Dest code 0000 off, 1 uart0, 2 uart1, 5 twi, 7 spi, d crc, f expanded_ram.
// RQ3: Peripheral register address is derived from the selected path code.
// RQ4: Only M2P, P2M, P2P; never EXPANDED_RAM to EXPANDED_RAM, never scratch-pad or flash.
// RQ5: Software leaves a selected peripheral's data register alone.
// RQ6: Block mode, or loop mode when enabled; one trigger runs until the count overflows.
// RQ7: Each transaction moves exactly one byte; 1 to 65536 per block.
// RQ8: Count is a 16-bit up-counter; ffff gives one transaction.
// RQ9: Count wrap ends transfer: clear go, set flag, reload count from base.
// RQ10: EXPANDED_RAM address comes from a 16-bit up-counter bumped per transaction.
// RQ11: End of transfer reloads the address counter from its base.
// RQ12: With the channel off both counters act as plain 16-bit timers.
// RQ13: Software sets go; selected external trigger also sets go.
// RQ14: Software configures, enables, waits for the flag, then disables.
// RQ15: Transfers run without CPU help; optional interrupt at end.
// RQ16: Clearing go suspends after the current byte; setting it resumes.
// RQ17: Loop mode reloads count and address and keeps serving requests.
// RQ18: With CRC copy on and dest not CRC, each byte also goes to CRC.
// RQ19: Interrupt only when flag, local enable and global enable all set.
// RQ20: Reserved or disabled path codes cause no data movement.
// RQ21: Address counter advances only on transactions that touch EXPANDED_RAM.
package sdma_pkg;

    typedef logic [15:0] sdma_word_t;

    // Path select codes
    localparam logic [3:0] SEL_OFF   = 4'h0;
    localparam logic [3:0] SEL_UART0 = 4'h1;
    localparam logic [3:0] SEL_UART1 = 4'h2;
    localparam logic [3:0] SEL_TWI   = 4'h5;
    localparam logic [3:0] SEL_SPI   = 4'h7;
    localparam logic [3:0] SEL_ADC   = 4'h9;
    localparam logic [3:0] SEL_CRC   = 4'hd;
    localparam logic [3:0] SEL_EXPANDED_RAM  = 4'hf;

    // Peripheral data register addresses, values arbitrary
    localparam logic [7:0] SFR_UART0 = 8'ha0;
    localparam logic [7:0] SFR_UART1 = 8'ha1;
    localparam logic [7:0] SFR_TWI   = 8'ha2;
    localparam logic [7:0] SFR_SPI   = 8'ha3;
    localparam logic [7:0] SFR_ADC   = 8'ha4;
    localparam logic [7:0] SFR_CRC   = 8'ha5;

    // Trigger select codes: software only or an external input
    localparam logic [1:0] TRIG_SW   = 2'h0;
    localparam logic [1:0] TRIG_INT2 = 2'h1;
    localparam logic [1:0] TRIG_KBI  = 2'h3;

    // Reset values and the last count before wrap
    localparam sdma_word_t WORD_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam sdma_word_t WORD_LAST  = 16'hffff;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b11
    } sdma_state_e;

    typedef struct packed {
        logic [3:0] src;
        logic [3:0] dst;
    } sdma_path_s;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       expanded_ram;
        sdma_word_t addr;
        logic [7:0] data;
    } sdma_acc_s;

    typedef struct packed {
        logic       wr;
        logic [7:0] data;
    } sdma_crc_s;

    typedef struct packed {
        sdma_word_t val;
    } sdma_cnt_s;

    typedef struct packed {
        sdma_state_e st;
        logic        go;
        logic        flag;
        logic        int2Prev;
        logic        kbiPrev;
        sdma_acc_s   acc;
        sdma_crc_s   crc;
    } sdma_core_s;

endpackage : sdma_pkg

/* sdma_counter.sv */
`timescale 1ns/1ps
module sdma_counter (
    input  wire logic               core_clk,
    input  wire logic               rstn,
    input  wire logic               load,
    input  sdma_pkg::sdma_word_t    loadVal,
    input  sdma_pkg::sdma_word_t    base,
    input  wire logic               rld,
    input  wire logic               inc,
    output sdma_pkg::sdma_word_t    value,
    output logic                    wrap
);

    sdma_pkg::sdma_cnt_s q;
    sdma_pkg::sdma_cnt_s d;

    // Wrap is a pulse on the increment that leaves ffff
    assign wrap  = inc && (q.val == sdma_pkg::WORD_LAST);
    assign value = q.val;

    // Software load beats reload; reload beats the plain step
    always_comb begin
        d = q;
        if (load) begin
            d.val = loadVal;
        end else if (rld) begin
            d.val = base;
        end else if (inc) begin
            d.val = q.val + 16'h0001;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            q.val <= sdma_pkg::WORD_RESET;
        end else begin
            q <= d;
        end
    end

endmodule : sdma_counter

/* sdma_core.sv */
`timescale 1ns/1ps
module sdma_core (
    input  wire logic               core_clk,
    input  wire logic               rstn,
    input  wire logic               channelOn,
    input  wire logic               goSet,
    input  wire logic               goClr,
    input  wire logic               flagClr,
    input  sdma_pkg::sdma_path_s    pathSel,
    input  wire logic               loopMode,
    input  wire logic               crcCopyEn,
    input  wire logic [1:0]         trigSel,
    input  wire logic               extInt2,
    input  wire logic               extKbi,
    input  wire logic               completionIrqEn,
    input  wire logic               globalXferIrqEn,
    input  wire logic               xferReq,
    input  wire logic [7:0]         rdData,
    input  wire logic               cntLoad,
    input  sdma_pkg::sdma_word_t    cntLoadVal,
    input  sdma_pkg::sdma_word_t    baseCount,
    input  wire logic               addrLoad,
    input  sdma_pkg::sdma_word_t    addrLoadVal,
    input  sdma_pkg::sdma_word_t    baseAddr,
    input  wire logic               cntTick,
    input  wire logic               addrTick,
    output sdma_pkg::sdma_acc_s     acc,
    output sdma_pkg::sdma_crc_s     crc,
    output logic                    goBit,
    output logic                    completionFlag,
    output logic                    irq,
    output logic                    busy,
    output sdma_pkg::sdma_word_t    countVal,
    output sdma_pkg::sdma_word_t    addrVal,
    output logic                    cntOvf,
    output logic                    addrOvf
);

    ////////////////////////////////////////////////////////////////////////
    // Path decode

    // Source codes outside the table move nothing
    function automatic logic srcValid(input logic [3:0] c);
        srcValid = (c == sdma_pkg::SEL_UART0) || // RQ1
                   (c == sdma_pkg::SEL_UART1) ||
                   (c == sdma_pkg::SEL_TWI)   ||
                   (c == sdma_pkg::SEL_SPI)   ||
                   (c == sdma_pkg::SEL_ADC)   ||
                   (c == sdma_pkg::SEL_EXPANDED_RAM);
    endfunction : srcValid

    // Destination codes outside the table move nothing
    function automatic logic dstValid(input logic [3:0] c);
        dstValid = (c == sdma_pkg::SEL_UART0) || // RQ2
                   (c == sdma_pkg::SEL_UART1) ||
                   (c == sdma_pkg::SEL_TWI)   ||
                   (c == sdma_pkg::SEL_SPI)   ||
                   (c == sdma_pkg::SEL_CRC)   ||
                   (c == sdma_pkg::SEL_EXPANDED_RAM);
    endfunction : dstValid

    // Data register address of a peripheral; page zero of SFR space
    function automatic logic [7:0] sfrAddr(input logic [3:0] c);
        sfrAddr = 8'h00;
        if (c == sdma_pkg::SEL_UART0) begin // RQ3
            sfrAddr = sdma_pkg::SFR_UART0;
        end else if (c == sdma_pkg::SEL_UART1) begin
            sfrAddr = sdma_pkg::SFR_UART1;
        end else if (c == sdma_pkg::SEL_TWI) begin
            sfrAddr = sdma_pkg::SFR_TWI;
        end else if (c == sdma_pkg::SEL_SPI) begin
            sfrAddr = sdma_pkg::SFR_SPI;
        end else if (c == sdma_pkg::SEL_ADC) begin
            sfrAddr = sdma_pkg::SFR_ADC;
        end else if (c == sdma_pkg::SEL_CRC) begin
            sfrAddr = sdma_pkg::SFR_CRC;
        end
    endfunction : sfrAddr

    sdma_pkg::sdma_core_s q;
    sdma_pkg::sdma_core_s d;

    logic srcX;
    logic dstX;
    logic pathOk;
    logic startOk;
    logic xferDone;
    logic extEdge;
    logic endEvt;
    logic cntInc;
    logic cntWrap;
    logic addrInc;
    logic addrRld;
    logic addrWrap;

    // EXPANDED_RAM to EXPANDED_RAM is refused like a reserved code
    assign srcX   = (pathSel.src == sdma_pkg::SEL_EXPANDED_RAM);
    assign dstX   = (pathSel.dst == sdma_pkg::SEL_EXPANDED_RAM);
    assign pathOk = srcValid(pathSel.src) && dstValid(pathSel.dst)
                    && !(srcX && dstX); // RQ4 RQ20

    ////////////////////////////////////////////////////////////////////////
    // Counters and trigger

    // One byte per pass; a cleared go is only seen back in idle
    assign startOk  = channelOn && q.go && pathOk && xferReq; // RQ16
    assign xferDone = (q.st == sdma_pkg::ST_WRITE); // RQ7

    // Rising edge only, so a held trigger starts one block
    assign extEdge = channelOn && (
        ((trigSel == sdma_pkg::TRIG_INT2) && extInt2 && !q.int2Prev) ||
        ((trigSel == sdma_pkg::TRIG_KBI) && extKbi && !q.kbiPrev));

    // Channel off turns both counters into free timers
    assign cntInc  = channelOn ? xferDone : cntTick; // RQ8 RQ12
    assign endEvt  = channelOn && cntWrap; // RQ9
    assign addrInc = channelOn ? (xferDone && (srcX || dstX))
                               : addrTick; // RQ10 RQ21
    assign addrRld = channelOn ? endEvt : addrWrap; // RQ11 RQ17

    sdma_counter uCount (
        .core_clk (core_clk),
        .rstn     (rstn),
        .load     (cntLoad),
        .loadVal  (cntLoadVal),
        .base     (baseCount),
        .rld      (cntWrap),
        .inc      (cntInc),
        .value    (countVal),
        .wrap     (cntWrap)
    );

    sdma_counter uAddr (
        .core_clk (core_clk),
        .rstn     (rstn),
        .load     (addrLoad),
        .loadVal  (addrLoadVal),
        .base     (baseAddr),
        .rld      (addrRld),
        .inc      (addrInc),
        .value    (addrVal),
        .wrap     (addrWrap)
    );

    ////////////////////////////////////////////////////////////////////////
    // Transfer engine

    // Next state; every set wins over a clear in the same cycle
    always_comb begin
        d          = q;
        d.acc.rd   = 1'b0;
        d.acc.wr   = 1'b0;
        d.crc.wr   = 1'b0;
        d.int2Prev = extInt2;
        d.kbiPrev  = extKbi;
        if (goClr) begin
            d.go = 1'b0;
        end
        if (endEvt && !loopMode) begin
            d.go = 1'b0; // RQ9 RQ6
        end
        if (goSet || extEdge) begin
            d.go = 1'b1; // RQ13
        end
        if (flagClr) begin
            d.flag = 1'b0;
        end
        if (endEvt) begin
            d.flag = 1'b1; // RQ9
        end
        case (q.st)
            sdma_pkg::ST_IDLE: begin
                if (startOk) begin
                    d.st       = sdma_pkg::ST_READ;
                    d.acc.rd   = 1'b1;
                    d.acc.expanded_ram = srcX;
                    d.acc.addr = srcX ? addrVal
                                      : {8'h00, sfrAddr(pathSel.src)};
                end
            end
            sdma_pkg::ST_READ: begin
                d.st       = sdma_pkg::ST_WRITE;
                d.acc.wr   = 1'b1;
                d.acc.expanded_ram = dstX;
                d.acc.addr = dstX ? addrVal
                                  : {8'h00, sfrAddr(pathSel.dst)};
                d.acc.data = rdData;
                d.crc.wr   = crcCopyEn
                             && (pathSel.dst != sdma_pkg::SEL_CRC); // RQ18
                d.crc.data = rdData;
            end
            sdma_pkg::ST_WRITE: begin
                d.st = sdma_pkg::ST_IDLE;
            end
            default: begin
                d.st = sdma_pkg::ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            q.st       <= sdma_pkg::ST_IDLE;
            q.go       <= 1'b0;
            q.flag     <= 1'b0;
            q.int2Prev <= 1'b0;
            q.kbiPrev  <= 1'b0;
            q.acc.rd   <= 1'b0;
            q.acc.wr   <= 1'b0;
            q.acc.expanded_ram <= 1'b0;
            q.acc.addr <= sdma_pkg::WORD_RESET;
            q.acc.data <= sdma_pkg::BYTE_RESET;
            q.crc.wr   <= 1'b0;
            q.crc.data <= sdma_pkg::BYTE_RESET;
        end else begin
            q <= d;
        end
    end

    // Outputs; interrupt stays valid while the CPU idles
    assign acc            = q.acc;
    assign crc            = q.crc;
    assign goBit          = q.go;
    assign completionFlag = q.flag;
    assign irq     = q.flag && completionIrqEn && globalXferIrqEn; // RQ19 RQ15
    assign busy    = (q.st != sdma_pkg::ST_IDLE);
    assign cntOvf  = !channelOn && cntWrap;
    assign addrOvf = !channelOn && addrWrap;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    a_flag_on_end: assert property ( // RQ9
        endEvt |=> completionFlag)
        else $error("flag not set after end of transfer");

    a_go_clr_end: assert property ( // RQ9
        endEvt && !loopMode && !goSet && !extEdge |=> !goBit)
        else $error("go still set after end of transfer");

    a_loop_keep: assert property ( // RQ17
        endEvt && loopMode && goBit && !goClr |=> goBit)
        else $error("loop mode dropped go");

    a_cnt_reload: assert property ( // RQ9
        endEvt && !cntLoad |=> countVal == $past(baseCount))
        else $error("count not reloaded from base");

    a_addr_reload: assert property ( // RQ11
        endEvt && !addrLoad |=> addrVal == $past(baseAddr))
        else $error("address not reloaded from base");

    a_rd_then_wr: assert property ( // RQ7
        acc.rd |=> acc.wr && !acc.rd ##1 !acc.wr && !acc.rd)
        else $error("byte transaction out of sequence");

    a_no_bad_path: assert property ( // RQ20 RQ4
        !pathOk && q.st == sdma_pkg::ST_IDLE |=> !acc.rd)
        else $error("read issued on a refused path");

    a_cnt_step: assert property ( // RQ8
        channelOn && acc.wr && !cntLoad && countVal != 16'hffff
        |=> countVal == $past(countVal) + 16'h0001)
        else $error("count did not step after a byte");

    a_addr_hold: assert property ( // RQ21
        channelOn && acc.wr && !acc.expanded_ram && !srcX && !addrLoad
        && !endEvt |=> $stable(addrVal))
        else $error("address moved on a peripheral-only byte");

    a_crc_copy: assert property ( // RQ18
        acc.wr |-> crc.wr == ($past(crcCopyEn)
                   && $past(pathSel.dst) != sdma_pkg::SEL_CRC))
        else $error("crc copy strobe wrong");

    a_irq_gate: assert property ( // RQ19
        irq |-> completionFlag && completionIrqEn && globalXferIrqEn)
        else $error("interrupt without all enables");

    a_timer_mode: assert property ( // RQ12
        !channelOn |-> !acc.rd && !endEvt)
        else $error("transfer activity with channel off");

    a_timer_flag: assert property ( // RQ12
        !channelOn && !completionFlag |=> !completionFlag)
        else $error("timer wrap raised the completion flag");

    a_irq_on_end: assert property ( // RQ19
        endEvt ##1 (completionIrqEn && globalXferIrqEn) |-> irq)
        else $error("no interrupt after end of transfer");

    a_go_on_set: assert property ( // RQ13
        goSet || extEdge |=> goBit)
        else $error("go not set by a trigger");

    a_suspend_hold: assert property ( // RQ16
        !busy && !goBit |=> !acc.rd)
        else $error("byte started while go was clear");

    c_block_end:  cover property (endEvt && !loopMode);
    c_loop_end:   cover property (endEvt && loopMode);
    c_crc_copy:   cover property (crc.wr && acc.wr);
    c_suspend:    cover property (goClr && busy);

endmodule : sdma_core

/* sdma_far_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Peripherals and EXPANDED_RAM behind the channel, answering the read strobe
module sdma_far_model (
    input  wire logic           core_clk,
    input  wire logic           rstn,
    input  sdma_pkg::sdma_acc_s acc,
    input  wire logic           stall,
    output logic                xferReq,
    output logic [7:0]          rdData
);
    logic [7:0] noise_q;

    // Free-running pattern so an unanswered bus never repeats old data
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            noise_q <= 8'h01;
        end else begin
            noise_q <= {noise_q[6:0], noise_q[7] ^ noise_q[5]};
        end
    end

    // Ready drops at random while stalled, like a slow peripheral
    assign xferReq = stall ? noise_q[0] : 1'h1;

    // Data only in the read cycle; EXPANDED_RAM and registers differ in pattern
    assign rdData = !acc.rd ? noise_q
                  : acc.addr[7:0] ^ (acc.expanded_ram ? 8'h3c : 8'hc3);
endmodule : sdma_far_model

/* sdma_core_bench.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
////////////////////////////////////////////////////////////////////////////////
module sdma_core_bench;
    logic                 core_clk = 1'h0;
    logic                 rstn = 1'h0;
    logic                 channelOn, goSet, goClr, flagClr, loopMode;
    logic                 crcCopyEn, extInt2, extKbi, stall, xferReq;
    logic                 completionIrqEn, globalXferIrqEn;
    logic                 cntLoad, addrLoad, cntTick, addrTick;
    logic [1:0]           trigSel;
    logic [7:0]           rdData;
    sdma_pkg::sdma_path_s pathSel;
    sdma_pkg::sdma_word_t cntLoadVal, baseCount, addrLoadVal, baseAddr;
    sdma_pkg::sdma_word_t countVal, addrVal;
    sdma_pkg::sdma_acc_s  acc;
    sdma_pkg::sdma_crc_s  crc;
    logic                 goBit, completionFlag, irq, busy, cntOvf, addrOvf;
    int                   fail_count = 0;
    int                   n_checks = 0;
    int                   cycles = 0;
    logic [3:0]           srcs [6] = '{4'h1, 4'h2, 4'h5, 4'h7, 4'h9, 4'hf};
    logic [3:0]           dsts [6] = '{4'h1, 4'h2, 4'h5, 4'h7, 4'hd, 4'hf};
    logic [7:0]           badPaths [5] = '{8'hdf, 8'h0f, 8'hff, 8'h99, 8'h10};

    sdma_core sdma_core_i (.*);
    sdma_far_model sdma_far_model_i (.*);

    // Clock and hang guard
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles > 40000) begin
            fail_count++;
            results();
        end
    end

    task results();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    // Inputs always change 2 ns after the rising edge
    task step();
        @(posedge core_clk);
        #2;
    endtask : step

    task waitRd();
        for (int i = 0; i < 100; i++) begin
            @(negedge core_clk);
            if (acc.rd === 1'h1) break;
        end
        `CHK(acc.rd, 1'h1)
    endtask : waitRd

    task waitIdle();
        for (int i = 0; i < 50; i++) begin
            @(negedge core_clk);
            if (busy === 1'h0) break;
        end
    endtask : waitIdle

    function automatic sdma_pkg::sdma_word_t sfrOf(input logic [3:0] c);
        case (c)
            sdma_pkg::SEL_UART0: sfrOf = {8'h00, sdma_pkg::SFR_UART0};
            sdma_pkg::SEL_UART1: sfrOf = {8'h00, sdma_pkg::SFR_UART1};
            sdma_pkg::SEL_TWI:   sfrOf = {8'h00, sdma_pkg::SFR_TWI};
            sdma_pkg::SEL_SPI:   sfrOf = {8'h00, sdma_pkg::SFR_SPI};
            sdma_pkg::SEL_ADC:   sfrOf = {8'h00, sdma_pkg::SFR_ADC};
            default:             sfrOf = {8'h00, sdma_pkg::SFR_CRC};
        endcase
    endfunction : sfrOf

    // One block of n bytes; every byte checked on both strobes
    task automatic run(input logic [3:0] s, input logic [3:0] d, input int n);
        sdma_pkg::sdma_word_t a0, ra, wa;
        logic sx, dx;
        sx = (s == sdma_pkg::SEL_EXPANDED_RAM);
        dx = (d == sdma_pkg::SEL_EXPANDED_RAM);
        a0 = 16'($urandom);
        step();
        pathSel = {s, d};
        {crcCopyEn, stall} = 2'($urandom);
        {completionIrqEn, globalXferIrqEn} = 2'($urandom);
        {baseCount, baseAddr} = 32'($urandom);
        cntLoadVal = 16'h0000 - 16'(n);
        addrLoadVal = a0;
        {cntLoad, addrLoad} = 2'h3;
        step();
        {cntLoad, addrLoad} = 2'h0;
        if (trigSel == sdma_pkg::TRIG_SW) goSet = 1'h1;
        else if (trigSel == sdma_pkg::TRIG_INT2) extInt2 = 1'h1;
        else extKbi = 1'h1;
        step();
        {goSet, extInt2, extKbi} = 3'h0;
        for (int k = 0; k < n; k++) begin
            waitRd();
            ra = sx ? a0 + 16'(k) : sfrOf(s);
            wa = dx ? a0 + 16'(k) : sfrOf(d);
            `CHK(acc.addr, ra)
            `CHK(acc.expanded_ram, sx)
            @(negedge core_clk);
            `CHK(acc.wr, 1'h1)
            `CHK(acc.addr, wa)
            `CHK(acc.data, ra[7:0] ^ (sx ? 8'h3c : 8'hc3))
            `CHK(crc.data, ra[7:0] ^ (sx ? 8'h3c : 8'hc3))
            `CHK(crc.wr, crcCopyEn && d != sdma_pkg::SEL_CRC)
            `CHK(countVal, cntLoadVal + 16'(k))
            `CHK(addrVal, (sx || dx) ? a0 + 16'(k) : a0)
        end
        @(negedge core_clk);
        `CHK(countVal, baseCount)
        `CHK(addrVal, baseAddr)
        `CHK(completionFlag, 1'h1)
        `CHK(goBit, loopMode)
        `CHK(irq, completionIrqEn & globalXferIrqEn)
        if (!loopMode) begin
            step();
            flagClr = 1'h1;
            step();
            flagClr = 1'h0;
            @(negedge core_clk);
            `CHK(completionFlag, 1'h0)
        end
    endtask : run

    // Main sequence
    initial begin
        {channelOn, goSet, goClr, flagClr, loopMode, crcCopyEn} = 6'h00;
        {extInt2, extKbi, completionIrqEn, globalXferIrqEn, stall} = 5'h00;
        {cntLoad, addrLoad, cntTick, addrTick, trigSel} = 6'h00;
        pathSel = 8'h00;
        {cntLoadVal, baseCount, addrLoadVal, baseAddr} = 64'h0;
        void'($urandom(56));
        repeat (4) @(posedge core_clk);
        #2 rstn = 1'h1;
        @(negedge core_clk);
        `CHK({countVal, addrVal}, 32'h0)
        `CHK({goBit, completionFlag, busy, acc.rd}, 4'h0)
        // Timers while the channel is off; software keeps off the data regs
        step();
        {cntLoadVal, addrLoadVal} = 32'hffff1234;
        {cntLoad, addrLoad} = 2'h3;
        step();
        {cntLoad, addrLoad, cntTick, addrTick} = 4'h3;
        @(negedge core_clk);
        `CHK({cntOvf, addrOvf}, 2'h2)
        step();
        {cntTick, addrTick, channelOn} = 3'h1;
        @(negedge core_clk);
        `CHK({countVal, addrVal}, {baseCount, 16'h1235})
        // Every code once, shortest block included
        for (int i = 0; i < 6; i++) run(srcs[i], dsts[(i + 1) % 6], 1 + i % 3);
        for (int i = 0; i < 10; i++) begin
            logic [3:0] s, d;
            s = srcs[$urandom % 6];
            d = dsts[$urandom % 6];
            if (s == d && s == sdma_pkg::SEL_EXPANDED_RAM) d = dsts[0];
            run(s, d, 1 + $urandom % 6);
        end
        // Refused paths move nothing
        foreach (badPaths[i]) begin
            step();
            pathSel = badPaths[i];
            goSet = 1'h1;
            step();
            goSet = 1'h0;
            repeat (12) @(negedge core_clk);
            `CHK({acc.rd, countVal}, {1'h0, baseCount})
            step();
            goClr = 1'h1;
            step();
            goClr = 1'h0;
        end
        // External triggers, edge taken
        step();
        trigSel = sdma_pkg::TRIG_INT2;
        run(4'h1, 4'hf, 2);
        step();
        trigSel = sdma_pkg::TRIG_KBI;
        run(4'hf, 4'h7, 1);
        step();
        trigSel = sdma_pkg::TRIG_SW;
        // Loop mode keeps serving after the wrap
        loopMode = 1'h1;
        run(4'h9, 4'hf, 1);
        waitRd();
        step();
        {loopMode, goClr} = 2'h1;
        step();
        goClr = 1'h0;
        waitIdle();
        // Suspend mid-byte: that byte finishes, then nothing until resumed
        step();
        {flagClr, cntLoad, cntLoadVal} = {2'h3, 16'hfff0};
        goSet = 1'h1;
        step();
        {flagClr, cntLoad, goSet} = 3'h0;
        waitRd();
        step();
        goClr = 1'h1;
        @(negedge core_clk);
        `CHK(acc.wr, 1'h1)
        step();
        goClr = 1'h0;
        repeat (12) @(negedge core_clk);
        `CHK({acc.rd, countVal}, {1'h0, 16'hfff1})
        step();
        goSet = 1'h1;
        step();
        goSet = 1'h0;
        waitRd();
        step();
        goClr = 1'h1;
        step();
        {goClr, channelOn} = 2'h0;
        pathSel = 8'h00;
        waitIdle();
        results();
    end
endmodule : sdma_core_bench
